// ===== sadc_consts.vh
// Constants for the serial converter control block.
// Assumes inclusion by bare name from the core and the bench.
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH

// ****************************************************
// Register byte offsets on the bus
// ****************************************************
`define SADC_CH0_OFS 8'h00
`define SADC_CH1_OFS 8'h04
`define SADC_CH2_OFS 8'h08
`define SADC_CH3_OFS 8'h0C
`define SADC_STAT_OFS 8'h10

// ****************************************************
// Status field positions
// ****************************************************
`define SADC_STAT_RES_LSB 0
`define SADC_STAT_CFG_LSB 8
`define SADC_STAT_BUSY_BIT 16
`define SADC_STAT_SEL_BIT 17
`define SADC_STAT_DONE_BIT 18

// ****************************************************
// Widths and reset values
// ****************************************************
`define SADC_RES_BITS 8
`define SADC_MUX_BITS 4
`define SADC_CH_RST 8'h00
`define SADC_CFG_RST 4'h0
`define SADC_CNT_RST 4'h0

// ****************************************************
// Serial sequence counts
// ****************************************************
`define SADC_MUX_LAST 4'h3
`define SADC_MSB_IDX 4'h7
`define SADC_LSB_START 4'h1

`endif

// ===== sadc_core.v
// Serial control and data interface of an 8-bit converter with a
// four-channel input multiplexer, plus a Wishbone register slave.
// Assumes the serial pins are asynchronous and much slower than
// core_clk; channel levels are supplied as codes over the bus.
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`include "sadc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sadc_core (
	input wire core_clk,
	input wire arst_n,
	input wire wb_cyc,
	input wire wb_stb,
	input wire wb_we,
	input wire [7:0] wb_adr,
	input wire [31:0] wb_dat_w,
	input wire [3:0] wb_sel,
	output reg [31:0] wb_dat_r,
	output reg wb_ack,
	input wire cs_n,
	input wire sclk,
	input wire serial_in,
	output reg sdo_out,
	output reg sdo_oe,
	output reg conv_in_progress,
	output reg conv_in_progress_oe
);

	// ****************************************************
	// States, one-hot
	// ****************************************************
	localparam [5:0] S_WAIT = 6'h01; // Looking for start bit
	localparam [5:0] S_ADDR = 6'h02; // Shifting config word
	localparam [5:0] S_GAP = 6'h04; // Waiting for settle edge
	localparam [5:0] S_CONV = 6'h08; // MSB-first decisions
	localparam [5:0] S_LSB = 6'h10; // LSB-first replay
	localparam [5:0] S_LOW = 6'h20; // Output parked low

	// ****************************************************
	// Pin synchronisation and edge detection
	// ****************************************************
	wire [2:0] pin_sync; // {cs_n, sclk, serial_in}
	reg sclk_d_ff; // Previous synced clock level
	wire cs_idle; // Select high, sequence held clear
	wire sclk_rise; // One-cycle pulse on rising edge
	wire sclk_fall; // One-cycle pulse on falling edge

	sadc_sync #(
		.WIDTH(3),
		.RST_VAL(3'h4)
	) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.async_in({cs_n, sclk, serial_in}),
		.sync_out(pin_sync)
	);

	assign cs_idle = pin_sync[2];
	assign sclk_rise = pin_sync[1] & ~sclk_d_ff;
	assign sclk_fall = ~pin_sync[1] & sclk_d_ff;

	// ****************************************************
	// Registers
	// ****************************************************
	reg [7:0] ch_ff [0:3]; // Channel level codes
	reg [5:0] state_ff, nxt_state; // Sequence state
	reg [3:0] cfg_ff, nxt_cfg; // Config word
	reg [3:0] cnt_ff, nxt_cnt; // Bit counter
	reg [7:0] sar_ff, nxt_sar; // Approximation result
	reg [7:0] diff_ff, nxt_diff; // Held input difference
	reg nxt_sdo, nxt_sdo_oe, nxt_busy;
	reg [7:0] last_res_ff; // Last finished result
	reg [3:0] last_cfg_ff; // Config of that result
	reg done_ff; // A result has been delivered
	wire [7:0] live_diff; // Difference from current config
	wire dec; // Comparator decision at this bit

	// ****************************************************
	// Helper functions
	// ****************************************************
	// Mask with one bit set at the given index
	function [7:0] bit_mask;
		input [3:0] idx;
		begin
			bit_mask = 8'h01 << idx[2:0];
		end
	endfunction

	// ****************************************************
	// Multiplexer decode and difference
	// ****************************************************
	// Config is {mode, sign, high select, low select}
	// Positive input is {high select, sign}; low select unused
	wire [1:0] plus_idx; // Assigned positive input
	wire [1:0] minus_idx; // Assigned negative input
	wire [7:0] v_plus, v_minus;

	assign plus_idx = {cfg_ff[1], cfg_ff[2]};
	assign minus_idx = {cfg_ff[1], ~cfg_ff[2]};
	assign v_plus = ch_ff[plus_idx];
	// Single-ended mode references the common return at ground
	assign v_minus = cfg_ff[3] ? 8'h00 : ch_ff[minus_idx];
	// Codes are already scaled so that 255 is full scale
	assign live_diff = (v_plus >= v_minus) ?
		(v_plus - v_minus) : 8'h00;

	// Decision: difference at or above the trial level
	assign dec = diff_ff >= (sar_ff | bit_mask(cnt_ff));

	// ****************************************************
	// Sequence next-state logic
	// ****************************************************
	always @*
	begin
		nxt_state = state_ff;
		nxt_cfg = cfg_ff;
		nxt_cnt = cnt_ff;
		nxt_sar = sar_ff;
		nxt_diff = diff_ff;
		nxt_sdo = sdo_out;
		nxt_sdo_oe = sdo_oe;
		nxt_busy = conv_in_progress;
		if (cs_idle)
		begin
			// Everything cleared while select is high
			nxt_state = S_WAIT;
			nxt_cfg = `SADC_CFG_RST;
			nxt_cnt = `SADC_CNT_RST;
			nxt_sar = 8'h00;
			nxt_diff = 8'h00;
			nxt_sdo = 1'b0;
			nxt_sdo_oe = 1'b0;
			nxt_busy = 1'b0;
		end
		else
		begin
			case (state_ff)
				S_WAIT:
				begin
					// Zeros ignored; a one is the start bit
					if (sclk_rise && pin_sync[0])
					begin
						nxt_state = S_ADDR;
						nxt_cnt = `SADC_CNT_RST;
					end
				end
				S_ADDR:
				begin
					// Output still floats while bits come in
					if (sclk_rise)
					begin
						nxt_cfg = {cfg_ff[2:0], pin_sync[0]};
						nxt_cnt = cnt_ff + 4'h1;
						if (cnt_ff == `SADC_MUX_LAST)
							nxt_state = S_GAP;
					end
				end
				S_GAP:
				begin
					// Settle half period ends at the falling edge;
					// input is no longer looked at from here on
					if (sclk_fall)
					begin
						nxt_busy = 1'b1;
						nxt_sdo_oe = 1'b1;
						nxt_sdo = 1'b0;
						nxt_diff = live_diff;
						nxt_sar = 8'h00;
						nxt_cnt = `SADC_MSB_IDX;
						nxt_state = S_CONV;
					end
				end
				S_CONV:
				begin
					// One decision per falling edge, MSB first
					if (sclk_fall)
					begin
						nxt_sdo = dec;
						nxt_sar = sar_ff | (dec ? bit_mask(cnt_ff) :
							8'h00);
						if (cnt_ff == `SADC_CNT_RST)
						begin
							nxt_cnt = `SADC_LSB_START;
							nxt_state = S_LSB;
						end
						else
							nxt_cnt = cnt_ff - 4'h1;
					end
				end
				S_LSB:
				begin
					// Bit 0 is shared, so replay starts at bit 1;
					// busy drops one period after the last decision
					if (sclk_fall)
					begin
						nxt_busy = 1'b0;
						nxt_sdo = sar_ff[cnt_ff[2:0]];
						if (cnt_ff == `SADC_MSB_IDX)
							nxt_state = S_LOW;
						else
							nxt_cnt = cnt_ff + 4'h1;
					end
				end
				S_LOW: // Parked low until select returns high
					if (sclk_fall)
						nxt_sdo = 1'b0;
				default: // Lost state code falls back to idle
					nxt_state = S_WAIT;
			endcase
		end
	end

	// ****************************************************
	// Sequence registers
	// ****************************************************
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_d_ff <= 1'b0;
			state_ff <= S_WAIT;
			cfg_ff <= `SADC_CFG_RST;
			cnt_ff <= `SADC_CNT_RST;
			sar_ff <= 8'h00;
			diff_ff <= 8'h00;
			sdo_out <= 1'b0;
			sdo_oe <= 1'b0;
			conv_in_progress <= 1'b0;
			conv_in_progress_oe <= 1'b0;
		end
		else
		begin
			sclk_d_ff <= pin_sync[1];
			state_ff <= nxt_state;
			cfg_ff <= nxt_cfg;
			cnt_ff <= nxt_cnt;
			sar_ff <= nxt_sar;
			diff_ff <= nxt_diff;
			sdo_out <= nxt_sdo;
			sdo_oe <= nxt_sdo_oe;
			conv_in_progress <= nxt_busy;
			// Busy pin floats whenever select is high
			conv_in_progress_oe <= ~cs_idle;
		end
	end

	// ****************************************************
	// Result capture for software
	// ****************************************************
	// Kept across select high so software can read it later
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			last_res_ff <= 8'h00;
			last_cfg_ff <= `SADC_CFG_RST;
			done_ff <= 1'b0;
		end
		else if (!cs_idle && state_ff == S_CONV && sclk_fall &&
			cnt_ff == `SADC_CNT_RST)
		begin
			last_res_ff <= nxt_sar;
			last_cfg_ff <= cfg_ff;
			done_ff <= 1'b1;
		end
		else if (!cs_idle && state_ff == S_GAP && sclk_fall)
			done_ff <= 1'b0;
	end

	// ****************************************************
	// Wishbone slave
	// ****************************************************
	// Answers every access one cycle after the strobe; an
	// unmapped read returns zero and an unmapped write is lost.
	wire wb_req; // New access this cycle
	wire [31:0] stat_word; // Status register contents
	integer i;

	assign wb_req = wb_cyc & wb_stb & ~wb_ack;
	assign stat_word = {13'h0000, done_ff, ~cs_idle,
		conv_in_progress, 4'h0, last_cfg_ff, last_res_ff};

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_ack <= 1'b0;
			wb_dat_r <= 32'h00000000;
			for (i = 0; i < 4; i = i + 1)
				ch_ff[i] <= `SADC_CH_RST;
		end
		else
		begin
			wb_ack <= wb_req;
			wb_dat_r <= 32'h00000000;
			if (wb_req && wb_we)
			begin
				// Channel codes live in byte lane 0
				if (wb_sel[0] && wb_adr[7:4] == 4'h0 &&
					wb_adr[1:0] == 2'h0)
					ch_ff[wb_adr[3:2]] <= wb_dat_w[7:0];
			end
			else if (wb_req)
			begin
				if (wb_adr[7:4] == 4'h0 && wb_adr[1:0] == 2'h0)
					wb_dat_r <= {24'h000000, ch_ff[wb_adr[3:2]]};
				else if (wb_adr == `SADC_STAT_OFS)
					wb_dat_r <= stat_word;
			end
		end
	end

endmodule // sadc_core

`default_nettype wire

// ===== sadc_host_model.sv
// Controller model: drives select, serial clock and data.
// Assumes core_clk is far faster than the serial clock.
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model #(
	parameter int HALF = 20
) (
	input wire logic core_clk,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	output logic cs_n,
	output logic sclk,
	output logic serial_in,
	output logic [16:0] rx_word,
	output logic rx_valid
);
	logic ser_pat; // Filler toggled after addressing
	// Idle: deselected, clock parked low between frames
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b0;
		rx_word = 17'h00000;
		rx_valid = 1'b0;
		ser_pat = 1'b0;
	end
	// One period; a floating output is seen as unknown
	task automatic tick(input logic din);
		serial_in <= din;
		repeat (HALF) @(posedge core_clk);
		sclk <= 1'b1;
		repeat (HALF) @(posedge core_clk);
		rx_word <= {rx_word[15:0], sdo_oe ? sdo_out : 1'bx};
		sclk <= 1'b0;
	endtask
	// Whole frame: zeros, start, config, then 17 read periods
	task automatic convert(input logic [3:0] cfg, input int zeros);
		int k;
		cs_n <= 1'b0;
		repeat (HALF) @(posedge core_clk);
		for (k = 0; k < zeros; k++)
			tick(1'b0);
		tick(1'b1);
		for (k = 3; k >= 0; k--)
			tick(cfg[k]);
		for (k = 0; k < 17; k++)
		begin
			ser_pat = ~ser_pat;
			tick(ser_pat); // Toggling input must be ignored now
		end
		repeat (HALF) @(posedge core_clk);
		rx_valid <= 1'b1;
		cs_n <= 1'b1;
		serial_in <= ~serial_in;
		@(posedge core_clk);
		rx_valid <= 1'b0;
		repeat (HALF) @(posedge core_clk);
	endtask
endmodule // sadc_host_model
`default_nettype wire

// ===== sadc_properties.sv
// Checker for the port behaviour of sadc_core.
// Assumes bind onto sadc_core; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sadc_properties (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [31:0] wb_dat_r,
	input wire logic wb_ack,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic conv_in_progress,
	input wire logic conv_in_progress_oe
);
	logic sclk_ff; // Previous sclk pin sample
	logic [4:0] busy_cnt_ff; // Falls seen while busy
	logic [4:0] oe_cnt_ff; // Falls seen while driving
	wire sfall = sclk_ff && !sclk; // Pin fall, one cycle late
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	// ****************************************************
	// Fall counters, zeroed whenever the output they count is low
	// ****************************************************
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_ff <= 1'b0;
			busy_cnt_ff <= 5'h00;
			oe_cnt_ff <= 5'h00;
		end
		else
		begin
			sclk_ff <= sclk;
			busy_cnt_ff <= conv_in_progress ? busy_cnt_ff + {4'h0, sfall} : 5'h00;
			oe_cnt_ff <= sdo_oe ? oe_cnt_ff + {4'h0, sfall} : 5'h00;
		end
	end
	// ****************************************************
	// Assertions
	// ****************************************************
	chk_ack_next: assert property ((wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
		else $error("ack not a one-cycle answer");
	chk_idle_data: assert property (!wb_ack |-> wb_dat_r == 32'h0000_0000)
		else $error("read data not zero while idle");
	chk_cs_float: assert property (cs_n [*6] |-> !sdo_oe && !conv_in_progress && !conv_in_progress_oe)
		else $error("outputs driven while deselected");
	chk_busy_drives: assert property (conv_in_progress |-> sdo_oe && conv_in_progress_oe)
		else $error("busy high with a floating pin");
	chk_lead_zero: assert property ($rose(sdo_oe) |-> !sdo_out)
		else $error("no leading zero when output enabled");
	chk_edge_only: assert property ((sclk && !cs_n) [*6] |-> $stable(sdo_out) && $stable(conv_in_progress))
		else $error("output moved while sclk high");
	chk_busy_span: assert property ((!cs_n && $fell(conv_in_progress)) |-> busy_cnt_ff == 5'h09)
		else $error("busy length wrong");
	chk_tail_low: assert property (oe_cnt_ff >= 5'h10 |-> ##2 !sdo_out)
		else $error("output not low after replay");
	cov_busy_done: cover property (!cs_n && $fell(conv_in_progress));
	cov_read: cover property (wb_ack && !wb_we);
	cov_tail: cover property (oe_cnt_ff == 5'h11);
endmodule // sadc_properties
bind sadc_core sadc_properties sadc_properties_i (.core_clk(core_clk),
	.arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
	.wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .cs_n(cs_n), .sclk(sclk),
	.sdo_out(sdo_out), .sdo_oe(sdo_oe), .conv_in_progress(conv_in_progress),
	.conv_in_progress_oe(conv_in_progress_oe));
`default_nettype wire

// ===== sadc_sync.v
// Two-stage level synchroniser for asynchronous pin inputs.
// Assumes inputs come from outside the core_clk domain.
`timescale 1ns/1ps
`default_nettype none

module sadc_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input wire core_clk,
	input wire arst_n,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	// First stage, read only by the second stage
	reg [WIDTH-1:0] meta_ff;
	// Second stage, safe for logic
	reg [WIDTH-1:0] sync_ff;

	// ****************************************************
	// Synchroniser chain
	// ****************************************************
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule // sadc_sync

`default_nettype wire

// ===== testbench.sv
// Self-checking bench for sadc_core with a controller model.
// Assumes channel codes are written over Wishbone before use.
`include "sadc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, cs_n, sclk;
	logic serial_in, sdo_out, sdo_oe, conv_in_progress, rx_valid;
	logic [7:0] wb_adr;
	logic [31:0] wb_dat_w, wb_dat_r, stat_exp;
	logic [3:0] wb_sel, cfg;
	logic [16:0] rx_word;
	logic [31:0] exp_rd[$]; // Pending read expectations
	logic [16:0] exp_ser[$]; // Pending serial frame expectations
	logic [7:0] ch[4]; // Channel codes last written
	int err_count = 0, n_compared = 0, cyc_cnt = 0, seed = 43228;
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	sadc_core sadc_core_i (.core_clk(core_clk), .arst_n(arst_n),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_dat_w(wb_dat_w), .wb_sel(wb_sel), .wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
		.sdo_out(sdo_out), .sdo_oe(sdo_oe), .conv_in_progress(conv_in_progress),
		.conv_in_progress_oe());
	sadc_host_model sadc_host_model_i (.core_clk(core_clk), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
		.rx_word(rx_word), .rx_valid(rx_valid));
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: read %h, want %h", $time, got, exp);
		end
	endtask
	task automatic cmp_ser(input logic [16:0] got, input logic [16:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: frame %h, want %h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold until ack is sampled, then drop a cycle
	task automatic wb_op(input logic we, input logic [7:0] adr,
		input logic [31:0] dat, input logic [3:0] sel);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat_w <= dat;
		wb_sel <= sel;
		@(posedge core_clk);
		while (wb_ack !== 1'b1)
			@(posedge core_clk);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		exp_rd.push_back(exp);
		wb_op(1'b0, adr, 32'h0000_0000, 4'hF);
	endtask
	// Code from the mux choice; negative difference clamps to zero
	// High select picks pair 0/1 or 2/3; sign makes the odd one plus
	function automatic logic [7:0] want_code(input logic [3:0] c);
		int pair;
		logic [7:0] p, m;
		pair = c[1] ? 2 : 0;
		p = ch[pair + (c[2] ? 1 : 0)];
		m = c[3] ? 8'h00 : ch[pair + (c[2] ? 0 : 1)];
		return (p > m) ? p - m : 8'h00;
	endfunction
	// Leading zero, MSB first, LSB-first replay from bit 1, then low
	function automatic logic [16:0] frame(input logic [7:0] r);
		return {1'b0, r, r[1], r[2], r[3], r[4], r[5], r[6], r[7], 1'b0};
	endfunction
	// Result watcher and hang guard
	always @(posedge core_clk)
	begin
		cyc_cnt++;
		if (wb_ack === 1'b1 && wb_we === 1'b0)
			cmp_rd(wb_dat_r, exp_rd.size() ? exp_rd.pop_front() : 32'hX);
		if (rx_valid === 1'b1)
			cmp_ser(rx_word, exp_ser.size() ? exp_ser.pop_front() : 17'hX);
		if (cyc_cnt > 30000)
		begin
			err_count++;
			give_verdict();
		end
	end
	initial
	begin
		arst_n = 1'b0;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} = '0;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 4; i++)
			rd(`SADC_CH0_OFS + 8'(i * 4), 32'h0000_0000);
		rd(8'h14, 32'h0000_0000);
		rd(`SADC_STAT_OFS, 32'h0000_0000);
		wb_op(1'b1, `SADC_CH0_OFS, 32'h0000_0055, 4'hE);
		rd(`SADC_CH0_OFS, 32'h0000_0000);
		// All eight mux choices, then full scale and a negative pair
		for (int n = 0; n < 10; n++)
		begin
			for (int i = 0; i < 4; i++)
			begin
				ch[i] = 8'($random(seed));
				if (n >= 8)
					ch[i] = (i == 0 && n == 8) || i == 1 ? 8'hFF : 8'h00;
				wb_op(1'b1, `SADC_CH0_OFS + 8'(i * 4), {24'h0, ch[i]}, 4'hF);
				rd(`SADC_CH0_OFS + 8'(i * 4), {24'h0, ch[i]});
			end
			cfg = n < 8 ? {n[2:0], 1'b1} : (n == 8 ? 4'h9 : 4'h1);
			exp_ser.push_back(frame(want_code(cfg)));
			sadc_host_model_i.convert(cfg, n % 4);
			// Stored result and config, done set, select and busy clear
			stat_exp = 32'(want_code(cfg)) | (32'(cfg) << `SADC_STAT_CFG_LSB);
			stat_exp = stat_exp | (32'h1 << `SADC_STAT_DONE_BIT);
			rd(`SADC_STAT_OFS, stat_exp);
		end
		repeat (10) @(posedge core_clk);
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
